// file: shared/conv_host_pkg.sv
// Constants, address map and state codes for the converter host port.
// Assumes one 100 MHz clock; the processor bus timing is emulated from it.
package conv_host_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PHI2_HALF_NS = 500;
    localparam int unsigned PHI2_HALF_CYC = (PHI2_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUS_CYC = 2 * PHI2_HALF_CYC;
    localparam int unsigned CNT_W = $clog2(BUS_CYC);
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [15:0] CONV_BASE_ADDR = 16'h5000;
    localparam logic [15:0] STORE_BASE_ADDR = 16'h0200;
    localparam logic [15:0] SINGLE_LAST_STORE = 16'h020F;
    localparam logic [15:0] ADAPTER_DATA_ADDR = 16'h8006;
    localparam logic [15:0] ADAPTER_CTRL_ADDR = 16'h8007;
    localparam logic [3:0] COARSE_BLOCK = 4'h5;
    localparam logic [2:0] UPPER_PAIR_BLOCK = 3'h2;
    localparam logic [3:0] SINGLE_LAST_IDX = 4'hF;
    localparam int unsigned MAX_CONV = 8;
    // ------------------------------------------------------------
    // Chip-select decode choices
    // ------------------------------------------------------------
    localparam logic [1:0] DEC_NARROW = 2'h0;
    localparam logic [1:0] DEC_COARSE = 2'h1;
    localparam logic [1:0] DEC_UPPER = 2'h2;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_WAIT = 5'h04,
        ST_READ = 5'h08,
        ST_DONE = 5'h10
    } host_state_t;
endpackage

// file: hdl/conv_host_port.sv
// Host-side attachment that starts, waits for and reads back 8-bit converters.
// Assumes converters on the pins below; data and interrupt pins are asynchronous.
// Behaviour
// - Separate read and write strobes come from one read/write line and phase two.
// - Outside the adapter variant, chip selects go active only while the valid-address flag is high.
// - Optional decode uses the whole 4XXX/5XXX pair as chip select.
// - Adapter variant holds chip select and read enable permanently active.
// - Adapter variant reads data at 8006 and writes control at 8007.
// - Multi mode: one write to 5000 starts every converter together.
// - Coarse decode selects on any 5XXX; narrow decode is available.
// - Readout starts only once every converter (multi) or the first converter (single) shows end of conversion.
// - Multi readout: addresses 5000-5007 stored at 0200-0207 in order.
// - Only the first converter runs its own clock; others take it.
// - Single mode restarts after each read, stops after storing at 020F.
// - Converter takes bus strobes directly: write starts, read outputs result.
`timescale 1ns/1ps
module conv_host_port #(
    parameter int unsigned NUM_CONV = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // User command port
    input wire logic run_start,
    input wire logic multi_mode,
    input wire logic adapter_mode,
    input wire logic [1:0] decode_mode,
    // User status and results
    output logic busy,
    output logic run_done,
    output logic store_valid,
    output logic [15:0] store_addr,
    output logic [7:0] store_data,
    // Emulated processor bus
    output logic [15:0] bus_addr,
    output logic bus_read,
    output logic phi2,
    output logic valid_address_flag,
    // Converter pins
    output logic [NUM_CONV-1:0] cs_n,
    output logic rd_n,
    output logic wr_n,
    input wire logic [7:0] conv_data,
    input wire logic [NUM_CONV-1:0] intr_n
);
    localparam logic [conv_host_pkg::CNT_W-1:0] CNT_LAST =
        conv_host_pkg::CNT_W'(conv_host_pkg::BUS_CYC - 1);
    localparam logic [conv_host_pkg::CNT_W-1:0] CNT_HALF =
        conv_host_pkg::CNT_W'(conv_host_pkg::PHI2_HALF_CYC);
    localparam logic [3:0] MULTI_LAST_IDX = 4'(NUM_CONV - 1);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [15:0] a, input logic [1:0] dm);
        logic hit;
        hit = 1'b0;
        if (dm == conv_host_pkg::DEC_COARSE) begin
            hit = (a[15:12] == conv_host_pkg::COARSE_BLOCK);
        end else if (dm == conv_host_pkg::DEC_UPPER) begin
            hit = (a[15:13] == conv_host_pkg::UPPER_PAIR_BLOCK);
        end else begin
            hit = (a[15:3] == conv_host_pkg::CONV_BASE_ADDR[15:3]);
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_CONV-1:0] intr_s1_reg, intr_s2_reg, intr_s3_reg, intr_filt_reg, intr_filt_next;
    logic [7:0] data_s1_reg, data_s2_reg, data_s3_reg, data_filt_reg, data_filt_next;
    logic all_ready;

    always_comb begin
        intr_filt_next = intr_filt_reg;
        data_filt_next = data_filt_reg;
        if (intr_s2_reg == intr_s3_reg) begin
            intr_filt_next = intr_s3_reg;
        end
        if (data_s2_reg == data_s3_reg) begin
            data_filt_next = data_s3_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intr_s1_reg <= '1;
            intr_s2_reg <= '1;
            intr_s3_reg <= '1;
            intr_filt_reg <= '1;
            data_s1_reg <= 8'h00;
            data_s2_reg <= 8'h00;
            data_s3_reg <= 8'h00;
            data_filt_reg <= 8'h00;
        end else begin
            intr_s1_reg <= intr_n;
            intr_s2_reg <= intr_s1_reg;
            intr_s3_reg <= intr_s2_reg;
            intr_filt_reg <= intr_filt_next;
            data_s1_reg <= conv_data;
            data_s2_reg <= data_s1_reg;
            data_s3_reg <= data_s2_reg;
            data_filt_reg <= data_filt_next;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and bus cycle engine
    // ------------------------------------------------------------
    conv_host_pkg::host_state_t state_reg, state_next;
    logic [conv_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [3:0] idx_reg, idx_next;
    logic multi_reg, multi_next, adapter_reg, adapter_next;
    logic [1:0] dec_reg, dec_next;
    logic cycle_end;

    // Only the first converter is ever read in single mode; its interrupt alone counts
    assign all_ready = multi_reg ? (intr_filt_reg == '0) : ~intr_filt_reg[0];
    assign cycle_end = (cnt_reg == CNT_LAST);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        multi_next = multi_reg;
        adapter_next = adapter_reg;
        dec_next = dec_reg;
        case (state_reg)
            conv_host_pkg::ST_IDLE: begin
                cnt_next = '0;
                if (run_start) begin
                    state_next = conv_host_pkg::ST_START;
                    idx_next = 4'h0;
                    adapter_next = adapter_mode;
                    multi_next = multi_mode && !adapter_mode;
                    dec_next = decode_mode;
                end
            end
            conv_host_pkg::ST_START: begin
                cnt_next = cycle_end ? '0 : cnt_reg + 1'b1;
                if (cycle_end) begin
                    state_next = conv_host_pkg::ST_WAIT;
                end
            end
            conv_host_pkg::ST_WAIT: begin
                cnt_next = '0;
                if (all_ready) begin
                    state_next = conv_host_pkg::ST_READ;
                end
            end
            conv_host_pkg::ST_READ: begin
                cnt_next = cycle_end ? '0 : cnt_reg + 1'b1;
                if (cycle_end) begin
                    if (multi_reg) begin
                        if (idx_reg == MULTI_LAST_IDX) begin
                            state_next = conv_host_pkg::ST_DONE;
                        end else begin
                            idx_next = idx_reg + 4'h1;
                        end
                    end else if (idx_reg == conv_host_pkg::SINGLE_LAST_IDX) begin
                        state_next = conv_host_pkg::ST_DONE;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                        state_next = conv_host_pkg::ST_START;
                    end
                end
            end
            conv_host_pkg::ST_DONE: begin
                state_next = conv_host_pkg::ST_IDLE;
                cnt_next = '0;
            end
            default: begin
                state_next = conv_host_pkg::ST_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= conv_host_pkg::ST_IDLE;
            cnt_reg <= '0;
            idx_reg <= 4'h0;
            multi_reg <= 1'b0;
            adapter_reg <= 1'b0;
            dec_reg <= conv_host_pkg::DEC_NARROW;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            multi_reg <= multi_next;
            adapter_reg <= adapter_next;
            dec_reg <= dec_next;
        end
    end

    // ------------------------------------------------------------
    // Registered pin and status outputs
    // ------------------------------------------------------------
    logic bus_cyc_next, rd_cyc_next, phase_hi_next, sel_next;
    logic [15:0] addr_next, store_addr_next;
    logic [NUM_CONV-1:0] cs_n_next;
    logic rd_n_next, wr_n_next, store_valid_next;
    logic bus_read_next, busy_next, run_done_next;
    logic [7:0] store_data_next;

    always_comb begin
        bus_cyc_next = (state_next == conv_host_pkg::ST_START) || (state_next == conv_host_pkg::ST_READ);
        rd_cyc_next = (state_next == conv_host_pkg::ST_READ);
        phase_hi_next = bus_cyc_next && (cnt_next >= CNT_HALF);
        addr_next = 16'h0000;
        if (adapter_next) begin
            addr_next = rd_cyc_next ? conv_host_pkg::ADAPTER_DATA_ADDR : conv_host_pkg::ADAPTER_CTRL_ADDR;
        end else if (bus_cyc_next) begin
            addr_next = rd_cyc_next ? (conv_host_pkg::CONV_BASE_ADDR | {12'h000, idx_next & {4{multi_next}}})
                                    : conv_host_pkg::CONV_BASE_ADDR;
        end
        sel_next = phase_hi_next && bus_cyc_next && addr_hit(addr_next, dec_next);
        cs_n_next = '1;
        for (int i = 0; i < NUM_CONV; i++) begin
            if (adapter_next) begin
                cs_n_next[i] = 1'b0;
            end else if (sel_next && !rd_cyc_next && (multi_next || i == 0)) begin
                cs_n_next[i] = 1'b0;
            end else if (sel_next && rd_cyc_next && (4'(i) == (idx_next & {4{multi_next}}))) begin
                cs_n_next[i] = 1'b0;
            end
        end
        rd_n_next = adapter_next ? 1'b0 : !(sel_next && rd_cyc_next);
        wr_n_next = !(phase_hi_next && !rd_cyc_next && (adapter_next || sel_next));
        bus_read_next = !bus_cyc_next || rd_cyc_next;
        busy_next = (state_next != conv_host_pkg::ST_IDLE);
        run_done_next = (state_next == conv_host_pkg::ST_DONE);
        // Data has settled through the synchroniser well before the cycle's last edge
        store_valid_next = (state_reg == conv_host_pkg::ST_READ) && cycle_end;
        store_addr_next = store_addr;
        store_data_next = store_data;
        if (store_valid_next) begin
            store_addr_next = conv_host_pkg::STORE_BASE_ADDR | {12'h000, idx_reg};
            store_data_next = data_filt_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_n <= '1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            bus_addr <= 16'h0000;
            bus_read <= 1'b1;
            phi2 <= 1'b0;
            valid_address_flag <= 1'b0;
            store_valid <= 1'b0;
            store_addr <= 16'h0000;
            store_data <= 8'h00;
            busy <= 1'b0;
            run_done <= 1'b0;
        end else begin
            cs_n <= cs_n_next;
            rd_n <= rd_n_next;
            wr_n <= wr_n_next;
            bus_addr <= addr_next;
            bus_read <= bus_read_next;
            phi2 <= phase_hi_next;
            valid_address_flag <= bus_cyc_next;
            store_valid <= store_valid_next;
            store_addr <= store_addr_next;
            store_data <= store_data_next;
            busy <= busy_next;
            run_done <= run_done_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_leave_wait;
        state_reg == conv_host_pkg::ST_WAIT ##1 state_reg == conv_host_pkg::ST_READ;
    endsequence
    sequence s_single_mid_read;
        state_reg == conv_host_pkg::ST_READ && cycle_end && !multi_reg && idx_reg != conv_host_pkg::SINGLE_LAST_IDX;
    endsequence

    a_cs_needs_vma: assert property (@(posedge clk) disable iff (rst)
        (cs_n != '1 && !adapter_reg) |-> (valid_address_flag && phi2)) else $error("chip select without valid address");
    a_rd_in_read: assert property (@(posedge clk) disable iff (rst)
        (!rd_n && !adapter_reg) |-> (phi2 && bus_read && valid_address_flag)) else $error("read strobe outside read phase");
    a_wr_in_write: assert property (@(posedge clk) disable iff (rst)
        !wr_n |-> (phi2 && !bus_read && valid_address_flag)) else $error("write strobe outside write phase");
    a_adapter_tied: assert property (@(posedge clk) disable iff (rst)
        (adapter_reg && busy) |=> (cs_n == '0 && !rd_n)) else $error("adapter select not held active");
    a_adapter_addrs: assert property (@(posedge clk) disable iff (rst)
        (adapter_reg && valid_address_flag) |->
        (bus_addr == (bus_read ? conv_host_pkg::ADAPTER_DATA_ADDR : conv_host_pkg::ADAPTER_CTRL_ADDR)))
        else $error("adapter address wrong");
    a_start_all: assert property (@(posedge clk) disable iff (rst)
        (!wr_n && multi_reg) |-> (cs_n == '0 && bus_addr == conv_host_pkg::CONV_BASE_ADDR))
        else $error("multi start missed a converter");
    a_read_gated: assert property (@(posedge clk) disable iff (rst)
        s_leave_wait |-> $past(all_ready)) else $error("readout before all converters ready");
    a_store_order: assert property (@(posedge clk) disable iff (rst)
        (store_valid && multi_reg) |-> (store_addr[15:3] == conv_host_pkg::STORE_BASE_ADDR[15:3]
        && $past(bus_addr[2:0]) == store_addr[2:0])) else $error("store address out of order");
    a_single_restart: assert property (@(posedge clk) disable iff (rst)
        s_single_mid_read |=> state_reg == conv_host_pkg::ST_START ##[1:200] !wr_n)
        else $error("single mode did not restart");
    a_single_stop: assert property (@(posedge clk) disable iff (rst)
        (store_valid && !multi_reg && store_addr == conv_host_pkg::SINGLE_LAST_STORE) |-> run_done)
        else $error("single mode did not stop at last location");
endmodule

// file: tb/conv_model.sv
// Behavioural model of up to eight 8-bit converters seen through their pins.
// Assumes strobes from the host port; conversion time is a cycle count set by the bench plus 13 cycles per converter index.
`timescale 1ns/1ps
module conv_model #(
    parameter int unsigned NUM_CONV = 8
) (
    // Clock, reset and bench controls
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic [7:0] res_base,
    input wire logic [15:0] delay,
    // Converter pins
    input wire logic [NUM_CONV-1:0] cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [7:0] conv_data,
    output logic [NUM_CONV-1:0] intr_n
);
    logic [15:0] cnt [NUM_CONV];
    logic [7:0] res [NUM_CONV];
    logic [7:0] nconv [NUM_CONV];
    logic [NUM_CONV-1:0] rd_prev;
    logic [7:0] last;
    logic drv;

    // Undriven bus shows the inverse of the last driven value
    always_comb begin
        drv = 1'b0;
        conv_data = ~last;
        for (int i = 0; i < NUM_CONV; i++) begin
            if (!cs_n[i] && !rd_n && !drv) begin
                drv = 1'b1;
                conv_data = res[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intr_n <= '1;
            rd_prev <= '0;
            last <= 8'h00;
            for (int i = 0; i < NUM_CONV; i++) begin
                cnt[i] <= 16'h0000;
                res[i] <= 8'h00;
                nconv[i] <= 8'h00;
            end
        end else begin
            if (drv) begin
                last <= conv_data;
            end
            for (int i = 0; i < NUM_CONV; i++) begin
                rd_prev[i] <= !cs_n[i] && !rd_n;
                if (clr) begin
                    nconv[i] <= 8'h00;
                end
                if (!cs_n[i] && !rd_n && !rd_prev[i]) begin
                    intr_n[i] <= 1'b1;
                end
                if (!cs_n[i] && !wr_n) begin
                    intr_n[i] <= 1'b1;
                    cnt[i] <= delay + 16'(13 * i);
                end else if (cnt[i] != 16'h0000) begin
                    // All converters step on one shared clock
                    cnt[i] <= cnt[i] - 16'h0001;
                    if (cnt[i] == 16'h0001) begin
                        intr_n[i] <= 1'b0;
                        res[i] <= res_base + 8'(16 * i) + nconv[i];
                        nconv[i] <= nconv[i] + 8'h01;
                    end
                end
            end
        end
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the converter host port with a converter model.
// Assumes the hand-over timing of the host port; inputs change on falling edges.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run_start = 1'b0, multi_mode = 1'b0, adapter_mode = 1'b0;
    logic [1:0] decode_mode = 2'h0;
    logic busy, run_done, store_valid, bus_read, phi2, valid_address_flag, rd_n, wr_n;
    logic [15:0] store_addr, bus_addr;
    logic [7:0] store_data, conv_data;
    logic [7:0] cs_n, intr_n;
    logic clr = 1'b0, multi_q = 1'b0, adapter_q = 1'b0, all_seen = 1'b0;
    logic [7:0] res_base_v = 8'h00;
    logic [15:0] delay_v = 16'h0014;
    int n_mismatch = 0;
    int n_checks = 0;

    conv_host_port #(.NUM_CONV(8)) u_conv_host_port (.clk(clk), .rst(rst), .run_start(run_start),
        .multi_mode(multi_mode), .adapter_mode(adapter_mode), .decode_mode(decode_mode), .busy(busy),
        .run_done(run_done), .store_valid(store_valid), .store_addr(store_addr), .store_data(store_data),
        .bus_addr(bus_addr), .bus_read(bus_read), .phi2(phi2), .valid_address_flag(valid_address_flag),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .conv_data(conv_data), .intr_n(intr_n));
    conv_model #(.NUM_CONV(8)) u_conv_model (.clk(clk), .rst(rst), .clr(clr), .res_base(res_base_v),
        .delay(delay_v), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .conv_data(conv_data), .intr_n(intr_n));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches=%0d checks=%0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Pin monitor
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (!rst) begin
            if (!wr_n) all_seen = 1'b0;
            if (intr_n === 8'h00) all_seen = 1'b1;
            check(16'(multi_q && !rd_n && !all_seen), 16'h0000);
            check(16'(!adapter_q && cs_n != 8'hFF && !valid_address_flag), 16'h0000);
            check(16'(!adapter_q && !rd_n && !(phi2 && valid_address_flag && bus_read)), 16'h0000);
            check(16'(!wr_n && !(phi2 && valid_address_flag && !bus_read)), 16'h0000);
            if (!wr_n) check(bus_addr, adapter_q ? 16'h8007 : 16'h5000);
            if (!wr_n && !adapter_q) check({8'h00, cs_n}, multi_q ? 16'h0000 : 16'h00FE);
            if (!rd_n && !adapter_q) check({8'h00, cs_n}, {8'h00, ~(8'h01 << bus_addr[2:0])});
            if (adapter_q && phi2) check({cs_n, 7'h00, rd_n}, 16'h0000);
            if (adapter_q && phi2 && bus_read) check(bus_addr, 16'h8006);
        end
    end

    // ------------------------------------------------------------
    // Run driver and result checks
    // ------------------------------------------------------------
    task automatic do_run(input logic m, input logic a, input logic [1:0] d, input logic [7:0] s,
                          input logic [15:0] dl, input int nexp, input logic poke);
        int n;
        logic [7:0] e;
        @(negedge clk);
        clr = 1'b1;
        res_base_v = s;
        delay_v = dl;
        multi_q = m && !a;
        adapter_q = a;
        multi_mode = m;
        adapter_mode = a;
        decode_mode = d;
        @(negedge clk);
        clr = 1'b0;
        run_start = 1'b1;
        n = 0;
        for (int t = 0; t < 40000 && run_done !== 1'b1; t++) begin
            @(negedge clk);
            run_start = poke && t == 300;
            if (store_valid === 1'b1) begin
                e = multi_q ? s + 8'(16 * n) : s + 8'(n);
                check(store_addr, 16'h0200 + 16'(n));
                check({8'h00, store_data}, {8'h00, e});
                n++;
            end
        end
        check(16'(n), 16'(nexp));
    endtask

    task automatic multi_narrow_prompt();
        do_run(1'b1, 1'b0, 2'h0, 8'h21, 16'h0014, 8, 1'b0);
    endtask

    task automatic multi_coarse_slow();
        do_run(1'b1, 1'b0, 2'h1, 8'h05, 16'h0190, 8, 1'b0);
    endtask

    task automatic single_narrow();
        do_run(1'b0, 1'b0, 2'h0, 8'h40, 16'h0032, 16, 1'b0);
    endtask

    task automatic single_upper_refused_start();
        do_run(1'b0, 1'b0, 2'h2, 8'h80, 16'h0014, 16, 1'b1);
        repeat (4) @(negedge clk);
        check(16'(busy), 16'h0000);
    endtask

    task automatic adapter_run();
        do_run(1'b1, 1'b1, 2'h0, 8'hC3, 16'h0064, 16, 1'b0);
        adapter_q = 1'b0;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(16'({cs_n, rd_n, wr_n, phi2, valid_address_flag, busy}), 16'h1FF8);
        check(bus_addr, 16'h0000);
        multi_narrow_prompt();
        multi_coarse_slow();
        single_narrow();
        single_upper_refused_start();
        adapter_run();
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
